//--- logic/fllc_pkg.sv
package fllc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ      = 125;
  localparam int CLK_HZ       = 125_000_000;
  localparam int SLOW_HZ      = 32_000;
  localparam int SLOW_DIV     = CLK_HZ / SLOW_HZ;
  localparam int START_NS     = 1000;
  localparam int START_CYC    = (START_NS * CLK_MHZ + 999) / 1000;
  localparam int LOCK_NS      = 2000;
  localparam int LOCK_CYC     = (LOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int DEB_TICKS    = 4;
  // ----------------------------------------
  // Register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [9:0] IDX_CTRL1  = 10'h171;
  localparam logic [9:0] IDX_FRC1   = 10'h177;
  localparam logic [9:0] IDX_RDB1   = 10'h178;
  localparam logic [9:0] IDX_SS1    = 10'h189;
  localparam logic [9:0] IDX_CTRL2  = 10'h191;
  localparam logic [9:0] IDX_FRC2   = 10'h197;
  localparam logic [9:0] IDX_RDB2   = 10'h198;
  localparam logic [9:0] IDX_SS2    = 10'h1a9;
  localparam logic [9:0] IDX_STATUS = 10'h1c0;
  localparam logic [9:0] IDX_ROUTE  = 10'h1c1;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int ENA_BIT     = 0;
  localparam int FREERUN_BIT = 1;
  localparam int APPLY_BIT   = 15;
  localparam int VALID_BIT   = 15;
  localparam int INTEG_W     = 12;
  localparam int SEL_LSB     = 0;
  localparam int RATE_LSB    = 2;
  localparam int DEPTH_LSB   = 4;
  localparam int SS_W        = 6;
  localparam logic [1:0]  CTRL_RST = 2'h2;
  localparam logic [11:0] FRC1_RST = 12'h281;
  localparam logic [11:0] FRC2_RST = 12'h000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MOD_OFF       = 2'b00,
    MOD_ZERO_MEAN = 2'b01,
    MOD_TRIANGLE  = 2'b10,
    MOD_DITHER    = 2'b11
  } fllc_mod_type;

  typedef enum logic [2:0] {
    LP_OFF     = 3'b000,
    LP_START   = 3'b001,
    LP_ACQUIRE = 3'b010,
    LP_LOCKED  = 3'b011,
    LP_FREERUN = 3'b100
  } fllc_state_type;

  // Depth in units of 0.1 %, rate in kHz
  typedef struct packed {
    logic                feedback_halt;
    logic [11:0]         integrator;
    fllc_mod_type        mod_select;
    logic [5:0]          mod_depth;
    logic [10:0]         mod_rate_khz;
  } fllc_loop_out_type;
endpackage

//--- logic/fllc_top.sv
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Operation
// - Free-run with loop enable halts feedback; oscillator ignores references.
// - Entering free-run from lock holds the latest integrator value.
// - A stopped reference leaves the loop running on its held integrator.
// - With free-run clear, loop re-locks once the reference returns.
// - Writing apply bit 15 loads the forced integrator, only in free-run.
// - Start-up in free-run uses reset value 281h (loop one), 000h (loop two).
// - Integrator readback is 12 bits with valid flag in bit 15.
// - Free-run enable resets to one.
// - A free-running loop can source the system or async domain clock.
// - Modulation select: 00 off, 01 zero-mean, 10 triangle, 11 dither.
// - Depth codes give 0.7/1.1/2.3/4.6 % triangle, 0.7/1.3/2.6/5.2 % zero-mean and dither.
// - Rate codes give 439k, 878k, 1.17M, 1.76M; triangle mode only.
// - Clock-OK rises once the loop has started and delivers a clock.
// - Lock status rises when the loop has locked to its reference.
// - Statuses reach interrupts through de-bounce needing 32kHz or system clock.
// - Status pins bypass de-bouncing and need no clock.
// - A loop-derived clock can drive a general-purpose pin.
module fllc_top (
  input  wire  logic                              CLOCK,
  input  wire  logic                              RST,
  input  wire  logic [11:0]                       AWADDR,
  input  wire  logic                              AWVALID,
  output logic                                    AWREADY,
  input  wire  logic [31:0]                       WDATA,
  input  wire  logic [3:0]                        WSTRB,
  input  wire  logic                              WVALID,
  output logic                                    WREADY,
  output logic [1:0]                              BRESP,
  output logic                                    BVALID,
  input  wire  logic                              BREADY,
  input  wire  logic [11:0]                       ARADDR,
  input  wire  logic                              ARVALID,
  output logic                                    ARREADY,
  output logic [31:0]                             RDATA,
  output logic [1:0]                              RRESP,
  output logic                                    RVALID,
  input  wire  logic                              RREADY,
  input  wire  logic [1:0]                        REF_PRESENT,
  input  wire  logic [1:0][11:0]                  INTEG_TRACK,
  input  wire  logic [1:0]                        LOOP_CLK,
  input  wire  logic                              SLOW_CLK_RUN,
  input  wire  logic                              SYSTEM_CLOCK_RUN,
  output fllc_pkg::fllc_loop_out_type [1:0]       LOOP_OUT,
  output logic [1:0]                              SYSTEM_CLOCK_FROM_LOOP,
  output logic [1:0]                              ASYNC_CLOCK_FROM_LOOP,
  output logic [1:0]                              IRQ_CLOCK_OK,
  output logic [1:0]                              IRQ_LOCK,
  output logic [1:0]                              GPIO_CLOCK_OK,
  output logic [1:0]                              GPIO_LOCK,
  output logic                                    GPIO_CLK_OUT
);
  import fllc_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] reg_kind(input logic [9:0] idx, output logic lp);
    lp = 1'b0;
    reg_kind = 2'h0;
    if (idx == IDX_CTRL2 || idx == IDX_FRC2 || idx == IDX_RDB2 || idx == IDX_SS2) begin
      lp = 1'b1;
    end
    if (idx == IDX_FRC1 || idx == IDX_FRC2) begin
      reg_kind = 2'h1;
    end else if (idx == IDX_RDB1 || idx == IDX_RDB2) begin
      reg_kind = 2'h2;
    end else if (idx == IDX_SS1 || idx == IDX_SS2) begin
      reg_kind = 2'h3;
    end
  endfunction

  function automatic logic mapped(input logic [9:0] idx);
    mapped = idx == IDX_CTRL1 || idx == IDX_FRC1 || idx == IDX_RDB1 || idx == IDX_SS1 ||
             idx == IDX_CTRL2 || idx == IDX_FRC2 || idx == IDX_RDB2 || idx == IDX_SS2 ||
             idx == IDX_STATUS || idx == IDX_ROUTE;
  endfunction

  // Depth in 0.1 % steps; zero-mean and dither share one table
  function automatic logic [5:0] depth_of(input logic [1:0] sel, input logic [1:0] code);
    logic [5:0] tri_t [4];
    logic [5:0] zm_t [4];
    tri_t = '{6'h07, 6'h0b, 6'h17, 6'h2e};
    zm_t  = '{6'h07, 6'h0d, 6'h1a, 6'h34};
    if (sel == MOD_OFF) begin
      depth_of = 6'h00;
    end else if (sel == MOD_TRIANGLE) begin
      depth_of = tri_t[code];
    end else begin
      depth_of = zm_t[code];
    end
  endfunction

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [1:0][1:0]      ctrl_q;
  logic [1:0][11:0]     frc_q;
  logic [1:0][5:0]      ss_q;
  logic [3:0]           route_q;
  logic [1:0]           apply_q;
  fllc_state_type       st_q [2];
  logic [1:0][11:0]     integ_q;
  logic [1:0][8:0]      cnt_q;

  // ----------------------------------------
  // AXI4-Lite write
  // ----------------------------------------
  logic                 aw_have_q;
  logic                 w_have_q;
  logic [9:0]           aw_idx_q;
  logic [31:0]          wdata_q;
  logic [3:0]           wstrb_q;
  logic                 wr_go;
  logic                 wr_lp;
  logic [1:0]           wr_kind;

  assign AWREADY = !aw_have_q && !BVALID;
  assign WREADY  = !w_have_q && !BVALID;
  assign wr_go   = aw_have_q && w_have_q && !BVALID;

  always_comb begin
    wr_kind = reg_kind(aw_idx_q, wr_lp);
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_idx_q  <= 10'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      BVALID    <= 1'b0;
      BRESP     <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_have_q <= 1'b1;
        aw_idx_q  <= AWADDR[11:2];
      end
      if (WVALID && WREADY) begin
        w_have_q <= 1'b1;
        wdata_q  <= WDATA;
        wstrb_q  <= WSTRB;
      end
      if (wr_go) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        BVALID    <= 1'b1;
        BRESP     <= mapped(aw_idx_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Software-owned fields
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      ctrl_q  <= {CTRL_RST, CTRL_RST};
      frc_q   <= {FRC2_RST, FRC1_RST};
      ss_q    <= '0;
      route_q <= 4'h0;
      apply_q <= 2'h0;
    end else begin
      apply_q <= 2'h0;
      if (wr_go && aw_idx_q == IDX_ROUTE && wstrb_q[0]) begin
        route_q <= wdata_q[3:0];
      end
      if (wr_go && mapped(aw_idx_q) && aw_idx_q != IDX_STATUS && aw_idx_q != IDX_ROUTE) begin
        unique case (wr_kind)
          2'h0: if (wstrb_q[0]) begin
            ctrl_q[wr_lp] <= wdata_q[1:0];
          end
          2'h1: begin
            if (wstrb_q[0]) begin
              frc_q[wr_lp][7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
              frc_q[wr_lp][11:8] <= wdata_q[11:8];
              apply_q[wr_lp]     <= wdata_q[APPLY_BIT];
            end
          end
          2'h2: begin
          end
          2'h3: if (wstrb_q[0]) begin
            ss_q[wr_lp] <= wdata_q[5:0];
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read
  // ----------------------------------------
  logic [9:0]           ar_idx;
  logic                 rd_lp;
  logic [1:0]           rd_kind;
  logic [31:0]          rd_word;

  assign ARREADY = !RVALID;
  assign ar_idx  = ARADDR[11:2];

  always_comb begin
    rd_kind = reg_kind(ar_idx, rd_lp);
    rd_word = 32'h0000_0000;
    if (ar_idx == IDX_STATUS) begin
      rd_word[3:0] = {GPIO_LOCK, GPIO_CLOCK_OK};
    end else if (ar_idx == IDX_ROUTE) begin
      rd_word[3:0] = route_q;
    end else if (mapped(ar_idx)) begin
      unique case (rd_kind)
        2'h0: rd_word[1:0] = ctrl_q[rd_lp];
        2'h1: rd_word[11:0] = frc_q[rd_lp];
        2'h2: begin
          rd_word[11:0]     = integ_q[rd_lp];
          rd_word[VALID_BIT] = st_q[rd_lp] == LP_FREERUN;
        end
        2'h3: rd_word[5:0] = ss_q[rd_lp];
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RVALID <= 1'b0;
      RDATA  <= 32'h0000_0000;
      RRESP  <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      RVALID <= 1'b1;
      RDATA  <= rd_word;
      RRESP  <= mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // ----------------------------------------
  // Loop sequencing
  // ----------------------------------------
  // Integrator only follows the analogue filter while feedback runs;
  // everywhere else it holds, except the start-up preset and apply loads in free-run; this keeps the output frequency steady.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      st_q[0] <= LP_OFF;
      st_q[1] <= LP_OFF;
      integ_q <= '0;
      cnt_q   <= '0;
    end else begin
      for (int l = 0; l < 2; l++) begin
        if (!ctrl_q[l][ENA_BIT]) begin
          st_q[l]  <= LP_OFF;
          cnt_q[l] <= 9'h000;
        end else begin
          unique case (st_q[l])
            LP_OFF: begin
              st_q[l]  <= LP_START;
              cnt_q[l] <= 9'h000;
              if (ctrl_q[l][FREERUN_BIT]) begin
                integ_q[l] <= (l == 0) ? FRC1_RST : FRC2_RST;
              end
            end
            LP_START: begin
              cnt_q[l] <= cnt_q[l] + 9'h001;
              if (cnt_q[l] == 9'(START_CYC - 1)) begin
                cnt_q[l] <= 9'h000;
                st_q[l]  <= ctrl_q[l][FREERUN_BIT] ? LP_FREERUN : LP_ACQUIRE;
              end
            end
            LP_ACQUIRE: begin
              if (ctrl_q[l][FREERUN_BIT]) begin
                st_q[l] <= LP_FREERUN;
              end else if (!REF_PRESENT[l]) begin
                cnt_q[l] <= 9'h000;
              end else begin
                integ_q[l] <= INTEG_TRACK[l];
                cnt_q[l]   <= cnt_q[l] + 9'h001;
                if (cnt_q[l] == 9'(LOCK_CYC - 1)) begin
                  st_q[l] <= LP_LOCKED;
                end
              end
            end
            LP_LOCKED: begin
              cnt_q[l] <= 9'h000;
              if (ctrl_q[l][FREERUN_BIT]) begin
                st_q[l] <= LP_FREERUN;
              end else if (!REF_PRESENT[l]) begin
                st_q[l] <= LP_ACQUIRE;
              end else begin
                integ_q[l] <= INTEG_TRACK[l];
              end
            end
            LP_FREERUN: begin
              cnt_q[l] <= 9'h000;
              if (!ctrl_q[l][FREERUN_BIT]) begin
                st_q[l] <= LP_ACQUIRE;
              end else if (apply_q[l]) begin
                integ_q[l] <= frc_q[l];
              end
            end
            default: st_q[l] <= LP_OFF;
          endcase
        end
      end
    end
  end

  // ----------------------------------------
  // Loop outputs and status
  // ----------------------------------------
  always_comb begin
    for (int l = 0; l < 2; l++) begin
      GPIO_CLOCK_OK[l] = st_q[l] != LP_OFF && st_q[l] != LP_START;
      GPIO_LOCK[l]     = st_q[l] == LP_LOCKED && REF_PRESENT[l];
      LOOP_OUT[l].feedback_halt = !((st_q[l] == LP_ACQUIRE || st_q[l] == LP_LOCKED)
                                    && REF_PRESENT[l]);
      LOOP_OUT[l].integrator = integ_q[l];
      LOOP_OUT[l].mod_select = fllc_mod_type'(ss_q[l][SEL_LSB +: 2]);
      LOOP_OUT[l].mod_depth  = depth_of(ss_q[l][SEL_LSB +: 2], ss_q[l][DEPTH_LSB +: 2]);
      unique case (ss_q[l][RATE_LSB +: 2])
        2'h0: LOOP_OUT[l].mod_rate_khz = 11'd439;
        2'h1: LOOP_OUT[l].mod_rate_khz = 11'd878;
        2'h2: LOOP_OUT[l].mod_rate_khz = 11'd1170;
        2'h3: LOOP_OUT[l].mod_rate_khz = 11'd1760;
      endcase
      if (ss_q[l][SEL_LSB +: 2] != MOD_TRIANGLE) begin
        LOOP_OUT[l].mod_rate_khz = 11'd0;
      end
    end
  end

  // Only a free-running loop may be picked as a domain source
  always_comb begin
    SYSTEM_CLOCK_FROM_LOOP = 2'h0;
    ASYNC_CLOCK_FROM_LOOP  = 2'h0;
    for (int l = 0; l < 2; l++) begin
      SYSTEM_CLOCK_FROM_LOOP[l] = route_q[l] && st_q[l] == LP_FREERUN;
      ASYNC_CLOCK_FROM_LOOP[l]  = route_q[2 + l] && st_q[l] == LP_FREERUN;
    end
  end

  // ----------------------------------------
  // Clock to pin
  // ----------------------------------------
  logic [1:0]           pin_sel_q;
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pin_sel_q <= 2'h0;
    end else begin
      pin_sel_q <= route_q[1:0];
    end
  end
  // Gated mux is a glitch hazard on select change; software switches while idle
  assign GPIO_CLK_OUT = (pin_sel_q[0] & LOOP_CLK[0] & GPIO_CLOCK_OK[0]) |
                        (pin_sel_q[1] & !pin_sel_q[0] & LOOP_CLK[1] & GPIO_CLOCK_OK[1]);

  // ----------------------------------------
  // De-bounce toward interrupts
  // ----------------------------------------
  logic [11:0]          div_q;
  logic                 tick;
  logic [3:0]           raw;
  logic [3:0]           deb_q;
  logic [3:0][1:0]      dcnt_q;

  assign raw  = {GPIO_LOCK, GPIO_CLOCK_OK};
  // Without either clock the filter freezes, so no interrupt can rise
  assign tick = SYSTEM_CLOCK_RUN || (SLOW_CLK_RUN && div_q == 12'h000);
  assign {IRQ_LOCK, IRQ_CLOCK_OK} = deb_q;

  always_ff @(posedge CLOCK) begin
    if (RST || div_q == 12'(SLOW_DIV - 1)) begin
      div_q <= 12'h000;
    end else begin
      div_q <= div_q + 12'h001;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      deb_q  <= 4'h0;
      dcnt_q <= '0;
    end else if (tick) begin
      for (int i = 0; i < 4; i++) begin
        if (raw[i] == deb_q[i]) begin
          dcnt_q[i] <= 2'h0;
        end else if (dcnt_q[i] == 2'(DEB_TICKS - 1)) begin
          deb_q[i]  <= raw[i];
          dcnt_q[i] <= 2'h0;
        end else begin
          dcnt_q[i] <= dcnt_q[i] + 2'h1;
        end
      end
    end
  end
endmodule // fllc_top

//--- verif/fllc_assertions.sv
`timescale 1ns/1ps
module fllc_assertions (
  input wire logic                             CLOCK,
  input wire logic                             RST,
  input wire logic                             AWVALID,
  input wire logic                             AWREADY,
  input wire logic                             WVALID,
  input wire logic                             WREADY,
  input wire logic [1:0]                       BRESP,
  input wire logic                             BVALID,
  input wire logic                             BREADY,
  input wire logic                             ARVALID,
  input wire logic                             ARREADY,
  input wire logic                             RVALID,
  input wire logic [1:0]                       REF_PRESENT,
  input wire logic                             SLOW_CLK_RUN,
  input wire logic                             SYSTEM_CLOCK_RUN,
  input wire fllc_pkg::fllc_loop_out_type [1:0] LOOP_OUT,
  input wire logic [1:0]                       SYSTEM_CLOCK_FROM_LOOP,
  input wire logic [1:0]                       IRQ_CLOCK_OK,
  input wire logic [1:0]                       GPIO_CLOCK_OK,
  input wire logic [1:0]                       GPIO_LOCK
);
  import fllc_pkg::*;
  // ----------------------------------------
  // Port behaviour
  // ----------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);
  sequence wr_both_taken;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence resp_waiting;
    BVALID && !BREADY;
  endsequence
  wr_answer_a: assert property (wr_both_taken |=> ##1 BVALID)
    else $error("write response missing");
  resp_hold_a: assert property (resp_waiting |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read data missing");
  depth_off_a: assert property (LOOP_OUT[0].mod_select == MOD_OFF |-> LOOP_OUT[0].mod_depth == 6'h0)
    else $error("depth nonzero while off");
  rate_tri_a: assert property (LOOP_OUT[0].mod_select != MOD_TRIANGLE |-> LOOP_OUT[0].mod_rate_khz == 11'h0)
    else $error("rate outside triangle");
  lock_fb_a: assert property (GPIO_LOCK[1] |-> !LOOP_OUT[1].feedback_halt && GPIO_CLOCK_OK[1])
    else $error("lock without running feedback");
  lock_ref_a: assert property ($rose(GPIO_LOCK[1]) |-> $past(REF_PRESENT[1]) && $past(REF_PRESENT[1], 8))
    else $error("lock without reference");
  route_free_a: assert property (SYSTEM_CLOCK_FROM_LOOP[0] |-> LOOP_OUT[0].feedback_halt && GPIO_CLOCK_OK[0])
    else $error("system clock from non free-running loop");
  irq_frozen_a: assert property ((!SYSTEM_CLOCK_RUN && !SLOW_CLK_RUN)[*2] |=> $stable(IRQ_CLOCK_OK))
    else $error("status de-bounce moved without clock");
endmodule // fllc_assertions

bind fllc_top fllc_assertions u_chk (
  .CLOCK, .RST, .AWVALID, .AWREADY, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARVALID, .ARREADY,
  .RVALID, .REF_PRESENT, .SLOW_CLK_RUN, .SYSTEM_CLOCK_RUN, .LOOP_OUT, .SYSTEM_CLOCK_FROM_LOOP,
  .IRQ_CLOCK_OK, .GPIO_CLOCK_OK, .GPIO_LOCK
);

//--- verif/fllc_ref_src.sv
`timescale 1ns/1ps
module fllc_ref_src (
  input  wire logic       clock,
  input  wire logic [1:0] ref_on,
  output logic [1:0]      ref_present,
  output logic [1:0][11:0] integ_track,
  output logic [1:0]      loop_clk
);
  // ----------------------------------------
  // Reference source and filter estimate
  // ----------------------------------------
  logic [3:0] cnt_q = 4'h0;
  always_ff @(posedge clock) begin
    cnt_q <= cnt_q + 4'h1;
  end
  assign ref_present = ref_on;
  // Estimate wanders every cycle so a held value differs from a tracked one
  assign integ_track[0] = {8'h40, cnt_q};
  assign integ_track[1] = {8'h41, cnt_q};
  assign loop_clk = {2{cnt_q[0]}};
endmodule // fllc_ref_src

//--- verif/fll_freerun_spread_status_ctrl_tb_top.sv
`timescale 1ns/1ps
module fll_freerun_spread_status_ctrl_tb_top;
  import fllc_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam logic [5:0]  TRI_DEP [4] = '{6'h07, 6'h0b, 6'h17, 6'h2e};
  localparam logic [5:0]  ALT_DEP [4] = '{6'h07, 6'h0d, 6'h1a, 6'h34};
  localparam logic [10:0] RATE_KHZ [4] = '{11'h1b7, 11'h36e, 11'h492, 11'h6e0};
  logic                    CLOCK = 1'h0;
  logic                    RST = 1'h1;
  logic                    AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
  logic                    SLOW_CLK_RUN = 1'h0, SYSTEM_CLOCK_RUN = 1'h0;
  logic [11:0]             AWADDR = 12'h0, ARADDR = 12'h0;
  logic [31:0]             WDATA = 32'h0;
  logic [1:0]              ref_on = 2'h0;
  logic                    AWREADY, WREADY, BVALID, ARREADY, RVALID, GPIO_CLK_OUT;
  logic [31:0]             RDATA;
  logic [1:0]              BRESP, RRESP, REF_PRESENT, LOOP_CLK, SYSTEM_CLOCK_FROM_LOOP, ASYNC_CLOCK_FROM_LOOP;
  logic [1:0]              IRQ_CLOCK_OK, IRQ_LOCK, GPIO_CLOCK_OK, GPIO_LOCK;
  logic [1:0][11:0]        INTEG_TRACK;
  fllc_loop_out_type [1:0] LOOP_OUT;
  int                      failures = 0, checked = 0;

  fllc_top dut (
    .CLOCK, .RST, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB(4'h3), .WVALID, .WREADY, .BRESP, .BVALID,
    .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .REF_PRESENT, .INTEG_TRACK,
    .LOOP_CLK, .SLOW_CLK_RUN, .SYSTEM_CLOCK_RUN, .LOOP_OUT, .SYSTEM_CLOCK_FROM_LOOP, .ASYNC_CLOCK_FROM_LOOP,
    .IRQ_CLOCK_OK, .IRQ_LOCK, .GPIO_CLOCK_OK, .GPIO_LOCK, .GPIO_CLK_OUT
  );
  fllc_ref_src u_ref (
    .clock(CLOCK), .ref_on(ref_on), .ref_present(REF_PRESENT), .integ_track(INTEG_TRACK), .loop_clk(LOOP_CLK)
  );
  initial begin
    forever #4 CLOCK = ~CLOCK;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits end on a falling edge so every check sees settled outputs
  task automatic cyc(input int n);
    repeat (n) @(negedge CLOCK);
  endtask
  task automatic xfer(input logic w_en, input logic [9:0] idx, input logic [15:0] d,
                      output logic [31:0] q, output logic [1:0] r);
    logic a, w, ar, b;
    int n;
    n = 0;
    b = 1'h0;
    @(posedge CLOCK);
    AWADDR <= {idx, 2'h0};
    ARADDR <= {idx, 2'h0};
    WDATA <= {16'h0, d};
    AWVALID <= w_en;
    WVALID <= w_en;
    BREADY <= w_en;
    ARVALID <= !w_en;
    RREADY <= !w_en;
    while (!b && n < 50) begin
      @(negedge CLOCK);
      a = AWREADY && AWVALID;
      w = WREADY && WVALID;
      ar = ARREADY && ARVALID;
      b = (BVALID && BREADY) || (RVALID && RREADY);
      r = w_en ? BRESP : RRESP;
      q = RDATA;
      n++;
      @(posedge CLOCK);
      if (a) AWVALID <= 1'h0;
      if (w) WVALID <= 1'h0;
      if (ar) ARVALID <= 1'h0;
      if (b) BREADY <= 1'h0;
      if (b) RREADY <= 1'h0;
    end
    if (!b) chk(32'h0, 32'h1);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [15:0] d, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    xfer(1'h1, idx, d, q, r);
    chk(32'(r), 32'(er));
  endtask
  task automatic rdc(input logic [9:0] idx, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0] r;
    xfer(1'h0, idx, 16'h0, q, r);
    chk(q, e);
    chk(32'(r), 32'(er));
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdc(IDX_CTRL1, 32'h2, RESP_OKAY);
    rdc(IDX_CTRL2, 32'h2, RESP_OKAY);
    rdc(IDX_FRC1, 32'h281, RESP_OKAY);
    rdc(IDX_FRC2, 32'h0, RESP_OKAY);
    rdc(IDX_RDB1, 32'h0, RESP_OKAY);
    rdc(IDX_SS2, 32'h0, RESP_OKAY);
    rdc(10'h100, 32'h0, RESP_SLVERR);
    wr(10'h100, 16'hffff, RESP_SLVERR);
    $display("t_reset done");
  endtask
  task automatic t_start;
    wr(IDX_CTRL1, 16'h3, RESP_OKAY);
    wr(IDX_CTRL2, 16'h3, RESP_OKAY);
    cyc(START_CYC + 8);
    chk(32'({GPIO_CLOCK_OK, IRQ_CLOCK_OK}), 32'hc);
    chk(32'({LOOP_OUT[1].integrator, LOOP_OUT[0].integrator}), 32'({FRC2_RST, FRC1_RST}));
    chk(32'({LOOP_OUT[1].feedback_halt, LOOP_OUT[0].feedback_halt}), 32'h3);
    rdc(IDX_RDB1, 32'h8281, RESP_OKAY);
    @(posedge CLOCK);
    SYSTEM_CLOCK_RUN <= 1'h1;
    cyc(12);
    chk(32'(IRQ_CLOCK_OK), 32'h3);
    rdc(IDX_STATUS, 32'h3, RESP_OKAY);
    $display("t_start done");
  endtask
  task automatic t_force;
    wr(IDX_FRC1, 16'h85a3, RESP_OKAY);
    cyc(3);
    chk(32'(LOOP_OUT[0].integrator), 32'h5a3);
    rdc(IDX_FRC1, 32'h5a3, RESP_OKAY);
    rdc(IDX_RDB1, 32'h85a3, RESP_OKAY);
    wr(IDX_FRC1, 16'h0123, RESP_OKAY);
    cyc(3);
    chk(32'(LOOP_OUT[0].integrator), 32'h5a3);
    wr(IDX_ROUTE, 16'h5, RESP_OKAY);
    cyc(2);
    chk(32'({ASYNC_CLOCK_FROM_LOOP, SYSTEM_CLOCK_FROM_LOOP}), 32'h5);
    repeat (2) begin
      cyc(1);
      chk(32'(GPIO_CLK_OUT), 32'(LOOP_CLK[0]));
    end
    $display("t_force done");
  endtask
  task automatic t_lock;
    logic [11:0] hold;
    @(posedge CLOCK);
    ref_on <= 2'h2;
    wr(IDX_CTRL2, 16'h1, RESP_OKAY);
    cyc(LOCK_CYC + 20);
    chk(32'({IRQ_LOCK[1], GPIO_LOCK[1], LOOP_OUT[1].feedback_halt}), 32'h6);
    wr(IDX_FRC2, 16'h8abc, RESP_OKAY);
    cyc(3);
    chk(32'(LOOP_OUT[1].integrator[11:4]), 32'h41);
    @(posedge CLOCK);
    ref_on <= 2'h0;
    cyc(4);
    hold = LOOP_OUT[1].integrator;
    cyc(20);
    chk(32'({GPIO_LOCK[1], GPIO_CLOCK_OK[1], LOOP_OUT[1].integrator}), 32'({2'h1, hold}));
    @(posedge CLOCK);
    ref_on <= 2'h2;
    cyc(LOCK_CYC + 20);
    chk(32'({IRQ_LOCK[1], GPIO_LOCK[1]}), 32'h3);
    @(posedge CLOCK);
    SYSTEM_CLOCK_RUN <= 1'h0;
    SLOW_CLK_RUN <= 1'h1;
    wr(IDX_CTRL2, 16'h3, RESP_OKAY);
    cyc(2);
    hold = LOOP_OUT[1].integrator;
    cyc(100);
    chk(32'({IRQ_LOCK[1], GPIO_LOCK[1], LOOP_OUT[1].feedback_halt, LOOP_OUT[1].integrator}),
        32'({3'h5, hold}));
    rdc(IDX_RDB2, 32'({4'h8, hold}), RESP_OKAY);
    cyc((DEB_TICKS + 1) * SLOW_DIV);
    chk(32'(IRQ_LOCK[1]), 32'h0);
    $display("t_lock done");
  endtask
  task automatic t_spread;
    logic [5:0] dep;
    logic [10:0] rate;
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 4; c++) begin
        dep = (s == 0) ? 6'h0 : ((s == 2) ? TRI_DEP[c] : ALT_DEP[c]);
        rate = (s == 2) ? RATE_KHZ[c] : 11'h0;
        wr(IDX_SS1, 16'(c * 20 + s), RESP_OKAY);
        cyc(2);
        chk(32'({LOOP_OUT[0].mod_select, LOOP_OUT[0].mod_depth, LOOP_OUT[0].mod_rate_khz}),
            32'({2'(s), dep, rate}));
        rdc(IDX_SS1, 32'(c * 20 + s), RESP_OKAY);
      end
    end
    $display("t_spread done");
  endtask
  // ----------------------------------------
  // Run control
  // ----------------------------------------
  // Software-side multiplier, kHz units: integer part, fraction reduced by gcd
  task automatic t_ratio;
    int v, f, a, b, t;
    v = 294912 / (1 * 3);
    f = 12000;
    a = v;
    b = f;
    while (b != 0) begin
      t = a % b;
      a = b;
      b = t;
    end
    chk(32'(v % f != 0), 32'h1);
    chk(32'(v / f), 32'h8);
    chk(32'((v % f) / a), 32'h18);
    chk(32'(f / a), 32'h7d);
    $display("t_ratio done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge CLOCK);
    RST <= 1'h0;
    t_reset;
    t_start;
    t_force;
    t_lock;
    t_spread;
    t_ratio;
    print_verdict;
  end
  // Whole run needs about 21k cycles; slow de-bounce dominates
  initial begin
    #400000;
    failures++;
    print_verdict;
  end
endmodule // fll_freerun_spread_status_ctrl_tb_top
